// ---- verilog/fra_top.sv ----
// Flash read accelerator: speculation buffer, small cache and bus slave.
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module fra_top
   import fra_pkg::*;
(
   input  wire logic                     clk_sys,
   input  wire logic                     rst,
   input  wire logic                     bus_rd,
   input  wire logic                     bus_wr,
   input  wire logic [fra_pkg::FRA_ADDR_W-1:0] bus_addr,
   input  wire logic [1:0]               bus_size,
   input  wire logic                     bus_instr,
   output logic [fra_pkg::FRA_WORD_W-1:0] bus_rdata,
   output logic                          bus_ready,
   output logic                          bus_err,
   input  wire logic                     ctl_cache_dis,
   input  wire logic                     ctl_instr_spec_dis,
   input  wire logic                     ctl_instr_cach_dis,
   input  wire logic                     ctl_data_spec_en,
   input  wire logic                     ctl_data_cach_dis,
   input  wire logic                     ctl_invalidate,
   input  wire logic                     pwr_flash_ok,
   input  wire logic [3:0]               flash_wait,
   output logic                          fl_rd,
   output logic [fra_pkg::FRA_ADDR_W-3:0] fl_addr,
   input  wire logic [fra_pkg::FRA_WORD_W-1:0] fl_rdata
);
   fra_flash_if fi ();

   fra_flash_port u_port (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .fi       (fi.port),
      .fl_rd    (fl_rd),
      .fl_addr  (fl_addr),
      .fl_rdata (fl_rdata)
   );

   // Lane select and sign-free zero extension of the requested bytes.
   function automatic logic [FRA_WORD_W-1:0] fra_lane(
      input logic [FRA_WORD_W-1:0] w,
      input logic [1:0]            ofs,
      input logic [1:0]            size);
      logic [FRA_WORD_W-1:0] s;
      s = w >> {ofs, 3'h0};
      case (size)
         FRA_SIZE_BYTE: fra_lane = {24'h000000, s[7:0]};
         FRA_SIZE_HALF: fra_lane = {16'h0000, s[15:0]};
         default:       fra_lane = w;
      endcase
   endfunction : fra_lane

   // Reset defaults: each control input flips its enable's reset value, so that
   // a control register at its zero reset value gives the defaults.
   logic en_cache;
   logic en_ispec;
   logic en_icach;
   logic en_dspec;
   logic en_dcach;
   assign en_cache = FRA_RST_CACHE_EN ^ ctl_cache_dis;
   assign en_ispec = FRA_RST_INSTR_SPEC ^ ctl_instr_spec_dis;
   assign en_icach = FRA_RST_INSTR_CACH ^ ctl_instr_cach_dis;
   assign en_dspec = FRA_RST_DATA_SPEC ^ ctl_data_spec_en;
   assign en_dcach = FRA_RST_DATA_CACH ^ ctl_data_cach_dis;

   // Storage: sixteen entries and the one-word speculation buffer.
   logic [FRA_WORD_W-1:0] dat_q [FRA_SETS][FRA_WAYS];
   logic [FRA_TAG_W-1:0]  tag_q [FRA_SETS][FRA_WAYS];
   logic                  vld_q [FRA_SETS][FRA_WAYS];
   logic [FRA_WAY_W-1:0]  rr_q  [FRA_SETS];
   logic [FRA_WORD_W-1:0] sb_dat_q;
   logic [FRA_ADDR_W-3:0] sb_adr_q;
   logic                  sb_vld_q;
   fra_state_e            st_q;
   fra_state_e            st_d;

   // Held request while the array is busy.
   logic [FRA_ADDR_W-1:0] rq_adr_q;
   logic [1:0]            rq_size_q;
   logic                  rq_instr_q;
   logic                  rq_pend_q;
   logic [FRA_ADDR_W-3:0] pf_adr_q;

   logic [FRA_ADDR_W-3:0] a_word;
   logic [FRA_SET_W-1:0]  a_set;
   logic [FRA_TAG_W-1:0]  a_tag;
   logic                  cache_on;
   logic                  spec_on;
   logic                  c_hit;
   logic [FRA_WORD_W-1:0] c_dat;
   logic                  s_hit;

   // Lookup addresses come from the held request once one is pending.
   logic [FRA_ADDR_W-1:0] l_adr;
   logic [1:0]            l_size;
   logic                  l_instr;
   assign l_adr   = rq_pend_q ? rq_adr_q   : bus_addr;
   assign l_size  = rq_pend_q ? rq_size_q  : bus_size;
   assign l_instr = rq_pend_q ? rq_instr_q : bus_instr;
   assign a_word  = l_adr[FRA_ADDR_W-1:2];
   assign a_set   = l_adr[2+FRA_SET_W-1:2];
   assign a_tag   = l_adr[FRA_ADDR_W-1:2+FRA_SET_W];
   // Per access type enables, forced off when flash is unreachable.
   assign cache_on = pwr_flash_ok && en_cache
                     && (l_instr ? en_icach : en_dcach);
   assign spec_on  = pwr_flash_ok
                     && (l_instr ? en_ispec : en_dspec);

   // Way compare across the indexed set.
   always_comb begin
      c_hit = 1'b0;
      c_dat = '0;
      for (int w = 0; w < FRA_WAYS; w++) begin
         if (vld_q[a_set][w] && tag_q[a_set][w] == a_tag) begin
            c_hit = cache_on;
            c_dat = dat_q[a_set][w];
         end
      end
   end
   assign s_hit = spec_on && sb_vld_q && (sb_adr_q == a_word);

   // Bus answer and sequencing of demand and prefetch reads.
   logic                  go_rd;
   logic                  ans_d;
   logic                  err_d;
   logic [FRA_WORD_W-1:0] rdat_d;
   logic                  fill;
   logic                  pf_fill;
   logic                  pend_d;
   logic                  start_dem;
   logic                  start_pf;
   assign go_rd = bus_rd && pwr_flash_ok;

   always_comb begin
      st_d      = st_q;
      ans_d     = 1'b0;
      err_d     = 1'b0;
      rdat_d    = '0;
      fill      = 1'b0;
      pf_fill   = 1'b0;
      pend_d    = rq_pend_q;
      start_dem = 1'b0;
      start_pf  = 1'b0;
      if (bus_wr) begin
         ans_d = 1'b1;
         err_d = 1'b1;
      end
      case (st_q)
         FRA_IDLE: begin
            if (go_rd || rq_pend_q) begin
               if (c_hit || s_hit) begin
                  ans_d  = 1'b1;
                  rdat_d = fra_lane(c_hit ? c_dat : sb_dat_q,
                                    l_adr[1:0], l_size);
                  pend_d = 1'b0;
                  if (spec_on && !(s_hit && !c_hit)) begin
                     start_pf = 1'b1;
                     st_d     = FRA_PREFETCH;
                  end else if (s_hit && spec_on) begin
                     start_pf = 1'b1;
                     st_d     = FRA_PREFETCH;
                  end
               end else begin
                  start_dem = 1'b1;
                  pend_d    = 1'b1;
                  st_d      = FRA_DEMAND;
               end
            end
         end
         FRA_DEMAND: begin
            if (fi.done) begin
               ans_d  = 1'b1;
               rdat_d = fra_lane(fi.rdata, rq_adr_q[1:0], rq_size_q);
               fill   = cache_on;
               pend_d = 1'b0;
               // The port is still busy with this read, so the prefetch
               // is launched from the prefetch state once it has let go.
               if (spec_on) begin
                  st_d = FRA_PREFETCH;
               end else begin
                  st_d = FRA_IDLE;
               end
            end
         end
         FRA_PREFETCH: begin
            // A new read waits for the prefetch; the master sees no ready.
            if (go_rd && !rq_pend_q) begin
               pend_d = 1'b1;
            end
            if (!fl_rd) begin
               start_pf = 1'b1;
            end
            if (fi.done) begin
               pf_fill = 1'b1;
               st_d    = FRA_IDLE;
            end
         end
         default: st_d = FRA_IDLE;
      endcase
      if (!pwr_flash_ok) begin
         st_d   = FRA_IDLE;
         pend_d = 1'b0;
      end
   end

   // Flash request: word address and wait setting from the flash module.
   logic [FRA_ADDR_W-3:0] nxt_word;
   // In the prefetch state the word after the last fetched one is wanted.
   assign nxt_word       = (st_q == FRA_PREFETCH ? pf_adr_q
                                                 : a_word) + 1'b1;
   assign fi.req         = start_dem || start_pf;
   assign fi.word_addr   = start_dem ? a_word
                           : (start_pf ? nxt_word : pf_adr_q);
   assign fi.wait_cycles = flash_wait;

   // Registers for answer, sequencer, request and buffer.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q       <= FRA_IDLE;
         bus_ready  <= 1'b0;
         bus_err    <= 1'b0;
         bus_rdata  <= '0;
         rq_pend_q  <= 1'b0;
         rq_adr_q   <= '0;
         rq_size_q  <= FRA_SIZE_WORD;
         rq_instr_q <= 1'b0;
         pf_adr_q   <= '0;
         sb_vld_q   <= 1'b0;
         sb_adr_q   <= '0;
         sb_dat_q   <= '0;
      end else begin
         st_q      <= st_d;
         bus_ready <= ans_d;
         bus_err   <= err_d;
         bus_rdata <= rdat_d;
         rq_pend_q <= pend_d;
         if (go_rd && !rq_pend_q) begin
            rq_adr_q   <= bus_addr;
            rq_size_q  <= bus_size;
            rq_instr_q <= bus_instr;
         end
         if (start_pf || start_dem) begin
            pf_adr_q <= fi.word_addr;
         end
         if (pf_fill) begin
            sb_vld_q <= 1'b1;
            sb_adr_q <= pf_adr_q;
            sb_dat_q <= fi.rdata;
         end
         if (!pwr_flash_ok) begin
            sb_vld_q <= 1'b0;
         end
      end
   end

   // Cache arrays, one generate slice per set.
   genvar gs;
   generate
      for (gs = 0; gs < FRA_SETS; gs++) begin : g_set
         logic wr_set;
         assign wr_set = fill && (rq_adr_q[2+FRA_SET_W-1:2] == gs);
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               rr_q[gs] <= FRA_RR_RESET;
               for (int w = 0; w < FRA_WAYS; w++) begin
                  vld_q[gs][w] <= 1'b0;
                  tag_q[gs][w] <= '0;
                  dat_q[gs][w] <= '0;
               end
            end else begin
               if (wr_set) begin
                  rr_q[gs] <= rr_q[gs] + 1'b1;
                  vld_q[gs][rr_q[gs]] <= 1'b1;
                  tag_q[gs][rr_q[gs]] <= rq_adr_q[FRA_ADDR_W-1:2+FRA_SET_W];
                  dat_q[gs][rr_q[gs]] <= fi.rdata;
               end
               if (ctl_invalidate) begin
                  // Invalidate wins over a same-cycle fill.
                  for (int w = 0; w < FRA_WAYS; w++) begin
                     vld_q[gs][w] <= 1'b0;
                  end
               end
            end
         end
      end
   endgenerate
endmodule : fra_top

// ---- verilog/fra_pkg.sv ----
// Package with shared constants and types for the flash read accelerator.
package fra_pkg;
   localparam int FRA_ADDR_W    = 20;
   localparam int FRA_SETS      = 4;
   localparam int FRA_WAYS      = 4;
   localparam int FRA_SET_W     = 2;
   localparam int FRA_WAY_W     = 2;
   localparam int FRA_WORD_W    = 32;
   localparam int FRA_TAG_W     = FRA_ADDR_W - 2 - FRA_SET_W;
   // Transfer size codes on the bus.
   localparam logic [1:0] FRA_SIZE_BYTE = 2'h0;
   localparam logic [1:0] FRA_SIZE_HALF = 2'h1;
   localparam logic [1:0] FRA_SIZE_WORD = 2'h2;
   // Reset values of the enables driven by the platform control register.
   localparam logic FRA_RST_CACHE_EN   = 1'b1;
   localparam logic FRA_RST_INSTR_SPEC = 1'b1;
   localparam logic FRA_RST_INSTR_CACH = 1'b1;
   localparam logic FRA_RST_DATA_SPEC  = 1'b0;
   localparam logic FRA_RST_DATA_CACH  = 1'b1;
   // Flash array access latency in cycles, plain default.
   localparam int FRA_FLASH_WAIT = 2;
   localparam logic [FRA_WAY_W-1:0] FRA_RR_RESET = 2'h0;

   typedef enum logic [1:0] {
      FRA_IDLE,
      FRA_DEMAND,
      FRA_PREFETCH
   } fra_state_e;
endpackage : fra_pkg

// ---- verilog/fra_flash_if.sv ----
// Interface between the accelerator control and the flash array port.
`timescale 1ns/1ps
interface fra_flash_if;
   import fra_pkg::*;
   logic                    req;
   logic [FRA_ADDR_W-3:0]   word_addr;
   logic [3:0]              wait_cycles;
   logic                    done;
   logic [FRA_WORD_W-1:0]   rdata;
   modport ctrl (output req, output word_addr, output wait_cycles,
                 input done, input rdata);
   modport port (input req, input word_addr, input wait_cycles,
                 output done, output rdata);
endinterface : fra_flash_if

// ---- verilog/fra_flash_port.sv ----
// Flash array sequencer: issues one word read and waits its access time.
`timescale 1ns/1ps
module fra_flash_port
   import fra_pkg::*;
(
   input  wire logic                    clk_sys,
   input  wire logic                    rst,
   fra_flash_if.port                    fi,
   output logic                         fl_rd,
   output logic [FRA_ADDR_W-3:0]        fl_addr,
   input  wire logic [FRA_WORD_W-1:0]   fl_rdata
);
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic       busy_q;
   logic       busy_d;
   // The array address is held in a register so that it stands unchanged
   // for the whole access and the top's output comes from a flip-flop.
   logic [FRA_ADDR_W-3:0] adr_q;
   logic [FRA_ADDR_W-3:0] adr_d;

   // Count down the wait cycles reported by the flash module.
   always_comb begin
      busy_d = busy_q;
      cnt_d  = cnt_q;
      adr_d  = adr_q;
      if (!busy_q && fi.req) begin
         busy_d = 1'b1;
         cnt_d  = fi.wait_cycles;
         adr_d  = fi.word_addr;
      end else if (busy_q) begin
         if (cnt_q == 4'h0) begin
            busy_d = 1'b0;
         end else begin
            cnt_d = cnt_q - 4'h1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         busy_q <= 1'b0;
         cnt_q  <= 4'h0;
         adr_q  <= '0;
      end else begin
         busy_q <= busy_d;
         cnt_q  <= cnt_d;
         adr_q  <= adr_d;
      end
   end

   assign fl_rd    = busy_q;
   assign fl_addr  = adr_q;
   assign fi.done  = busy_q && (cnt_q == 4'h0);
   assign fi.rdata = fl_rdata;
endmodule : fra_flash_port

// ---- testbench/fra_top_asserts.sv ----
// Concurrent checks on the ports of the flash read accelerator.
`timescale 1ns/1ps
module fra_top_asserts
(
   input wire logic                            clk_sys,
   input wire logic                            rst,
   input wire logic                            bus_rd,
   input wire logic                            bus_wr,
   input wire logic                            bus_ready,
   input wire logic                            bus_err,
   input wire logic                            pwr_flash_ok,
   input wire logic [3:0]                      flash_wait,
   input wire logic                            fl_rd,
   input wire logic [fra_pkg::FRA_ADDR_W-3:0]  fl_addr
);
   import fra_pkg::*;
   logic [4:0] run_q;
   logic [4:0] run_d;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Length of the current array access, so its wait setting can be judged.
   always_comb begin
      run_d = fl_rd ? run_q + 5'h1 : 5'h0;
   end
   always_ff @(posedge clk_sys) begin
      run_q <= rst ? 5'h0 : run_d;
   end
   a_wr_err_next: assert property (bus_wr |=> bus_ready && bus_err)
      else $error("write not answered by a bus error");
   a_err_from_wr: assert property (bus_err |-> $past(bus_wr))
      else $error("bus error without a write");
   a_rd_answered: assert property (bus_rd && pwr_flash_ok |-> ##[1:40] bus_ready)
      else $error("read not answered in time");
   a_ready_one_cycle: assert property (bus_ready |=> !bus_ready)
      else $error("answer stands longer than one cycle");
   a_quiet_after_rst: assert property ($fell(rst) |-> !bus_ready && !fl_rd)
      else $error("activity right after reset");
   a_fl_addr_hold: assert property (fl_rd && $past(fl_rd) |-> $stable(fl_addr))
      else $error("array address moved during an access");
   a_fl_len_wait: assert property ($fell(fl_rd) |-> run_q == 5'(flash_wait) + 5'h1)
      else $error("array access length differs from wait setting");
   a_off_no_fetch: assert property (!pwr_flash_ok && !$past(pwr_flash_ok) |-> !fl_rd)
      else $error("array read while flash is unavailable");
   a_off_no_answer: assert property (bus_rd && !pwr_flash_ok |=> !bus_ready [*3])
      else $error("read answered while flash is unavailable");
   c_write_err: cover property (bus_wr ##1 bus_err);
   c_fast_hit: cover property (bus_rd ##1 bus_ready);
   c_array_read: cover property ($fell(fl_rd));
endmodule : fra_top_asserts

// ---- testbench/fra_flash_model.sv ----
// Behavioural program flash array answering the accelerator's word reads.
`timescale 1ns/1ps
module fra_flash_model
(
   input  wire logic                            clk_sys,
   input  wire logic [3:0]                      flash_wait,
   input  wire logic                            fl_rd,
   input  wire logic [fra_pkg::FRA_ADDR_W-3:0]  fl_addr,
   output logic      [fra_pkg::FRA_WORD_W-1:0]  fl_rdata
);
   import fra_pkg::*;
   int                    n_q = 0;
   logic [FRA_WORD_W-1:0] last_q = 32'h0;
   logic                  valid;
   // Data is only good on the last cycle of an access; at any other moment
   // the lines show the inverse of the last word so early sampling fails.
   assign valid = fl_rd && (n_q == int'(flash_wait));
   assign fl_rdata = valid ? (32'h5A00_0000 ^ {14'h0, fl_addr}) : ~last_q;
   // Count access cycles and remember the last word shown.
   always_ff @(posedge clk_sys) begin
      n_q <= fl_rd ? n_q + 1 : 0;
      if (valid) last_q <= fl_rdata;
   end
endmodule : fra_flash_model

// ---- testbench/fra_top_bench.sv ----
// Self-checking testbench of the flash read accelerator.
`timescale 1ns/1ps
module fra_top_bench;
   import fra_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        bus_rd = 1'b0;
   logic        bus_wr = 1'b0;
   logic [19:0] bus_addr = 20'h0;
   logic [1:0]  bus_size = 2'h0;
   logic        bus_instr = 1'b0;
   logic [31:0] bus_rdata;
   logic        bus_ready;
   logic        bus_err;
   logic [4:0]  ctl = 5'h0;
   logic        inval = 1'b0;
   logic        pwr_flash_ok = 1'b1;
   logic [3:0]  flash_wait = 4'h3;
   logic        fl_rd;
   logic [17:0] fl_addr;
   logic [31:0] fl_rdata;
   int          failures = 0;
   int          n_compared = 0;
   // Free-running system clock, 10 ns period.
   always #5 clk_sys = ~clk_sys;
   // Control bits arrive as plain inputs from outside the block.
   fra_top dut (.clk_sys(clk_sys), .rst(rst), .bus_rd(bus_rd), .bus_wr(bus_wr),
      .bus_addr(bus_addr), .bus_size(bus_size), .bus_instr(bus_instr),
      .bus_rdata(bus_rdata), .bus_ready(bus_ready), .bus_err(bus_err),
      .ctl_cache_dis(ctl[4]), .ctl_instr_spec_dis(ctl[3]),
      .ctl_instr_cach_dis(ctl[2]), .ctl_data_spec_en(ctl[1]),
      .ctl_data_cach_dis(ctl[0]), .ctl_invalidate(inval),
      .pwr_flash_ok(pwr_flash_ok), .flash_wait(flash_wait),
      .fl_rd(fl_rd), .fl_addr(fl_addr), .fl_rdata(fl_rdata));
   fra_flash_model u_flash (.clk_sys(clk_sys), .flash_wait(flash_wait),
      .fl_rd(fl_rd), .fl_addr(fl_addr), .fl_rdata(fl_rdata));
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Expected bytes of a read, shifted down to bit 0 and zero-extended.
   function automatic logic [31:0] lane(input logic [19:0] a,
                                        input logic [1:0] sz);
      logic [31:0] w;
      w = (32'h5A00_0000 ^ {14'h0, a[19:2]}) >> (8 * a[1:0]);
      return (sz == FRA_SIZE_BYTE) ? (w & 32'hFF) :
             (sz == FRA_SIZE_HALF) ? (w & 32'hFFFF) : w;
   endfunction : lane
   function automatic int miss();
      return int'(flash_wait) + 2;
   endfunction : miss
   // One read; checks data and the cycles from the taking edge to the answer.
   task automatic rc(input logic [19:0] a, input logic [1:0] sz,
                     input logic ins, input int exp_lat);
      int lat;
      lat = 1;
      @(posedge clk_sys);
      bus_rd <= 1'b1;
      bus_addr <= a;
      bus_size <= sz;
      bus_instr <= ins;
      @(posedge clk_sys);
      bus_rd <= 1'b0;
      // A hit answers from the taking edge itself, so look just after it.
      #1;
      while (lat < 60 && bus_ready !== 1'b1) begin
         @(posedge clk_sys);
         #1;
         lat++;
      end
      if (bus_ready !== 1'b1) begin
         failures++;
         report_and_stop();
      end
      chk("read data", lane(a, sz), bus_rdata);
      chk("read latency", 32'(exp_lat), 32'(lat));
      repeat (25) @(posedge clk_sys);
   endtask : rc
   // Controls change only while no flash access is going on.
   task automatic set_ctl(input logic [4:0] v);
      @(posedge clk_sys);
      ctl <= v;
      repeat (3) @(posedge clk_sys);
   endtask : set_ctl
   task automatic t_sizes();
      rc(20'h00100, FRA_SIZE_WORD, 1'b0, miss());
      for (int i = 0; i < 4; i++) begin
         rc(20'h00100 + 20'(i), FRA_SIZE_BYTE, 1'b0, 1);
      end
      rc(20'h00102, FRA_SIZE_HALF, 1'b0, 1);
      @(posedge clk_sys);
      bus_wr <= 1'b1;
      bus_addr <= 20'h00100;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
      #1;
      chk("write answer", 32'h3, {30'h0, bus_ready, bus_err});
      rc(20'h00100, FRA_SIZE_WORD, 1'b0, 1);
   endtask : t_sizes
   // Five words into one set; the oldest way is replaced first.
   task automatic t_ways();
      for (int i = 0; i < 4; i++) begin
         rc(20'h0100C + 20'(16 * i), FRA_SIZE_WORD, 1'b0, miss());
      end
      for (int i = 0; i < 4; i++) begin
         rc(20'h0100C + 20'(16 * i), FRA_SIZE_WORD, 1'b0, 1);
      end
      rc(20'h0104C, FRA_SIZE_WORD, 1'b0, miss());
      rc(20'h0100C, FRA_SIZE_WORD, 1'b0, miss());
      rc(20'h0102C, FRA_SIZE_WORD, 1'b0, 1);
      @(posedge clk_sys);
      inval <= 1'b1;
      @(posedge clk_sys);
      inval <= 1'b0;
      rc(20'h0102C, FRA_SIZE_WORD, 1'b0, miss());
   endtask : t_ways
   task automatic t_spec();
      rc(20'h00204, FRA_SIZE_WORD, 1'b1, miss());
      rc(20'h00208, FRA_SIZE_WORD, 1'b1, 1);
      rc(20'h00300, FRA_SIZE_WORD, 1'b0, miss());
      rc(20'h00304, FRA_SIZE_WORD, 1'b0, miss());
      set_ctl(5'h02);
      rc(20'h00400, FRA_SIZE_WORD, 1'b0, miss());
      rc(20'h00404, FRA_SIZE_WORD, 1'b0, 1);
      set_ctl(5'h0C);
      rc(20'h00500, FRA_SIZE_WORD, 1'b1, miss());
      rc(20'h00500, FRA_SIZE_WORD, 1'b1, miss());
      rc(20'h00504, FRA_SIZE_WORD, 1'b1, miss());
      set_ctl(5'h10);
      rc(20'h00600, FRA_SIZE_WORD, 1'b0, miss());
      rc(20'h00600, FRA_SIZE_WORD, 1'b0, miss());
      set_ctl(5'h00);
      // Let the new wait setting land before the expectation reads it.
      flash_wait <= 4'h0;
      @(posedge clk_sys);
      rc(20'h00700, FRA_SIZE_WORD, 1'b0, miss());
      flash_wait <= 4'h7;
      @(posedge clk_sys);
      rc(20'h00800, FRA_SIZE_WORD, 1'b0, miss());
   endtask : t_spec
   // Reads are ignored while the power mode has no flash.
   task automatic t_power();
      int seen;
      seen = 0;
      @(posedge clk_sys);
      pwr_flash_ok <= 1'b0;
      @(posedge clk_sys);
      bus_rd <= 1'b1;
      bus_addr <= 20'h00900;
      @(posedge clk_sys);
      bus_rd <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_sys);
         #1;
         seen += int'(bus_ready === 1'b1 || fl_rd === 1'b1);
      end
      chk("power off activity", 32'h0, 32'(seen));
      @(posedge clk_sys);
      pwr_flash_ok <= 1'b1;
      rc(20'h00900, FRA_SIZE_WORD, 1'b0, miss());
   endtask : t_power
   // Main sequence: reset, then every scenario, then the verdict.
   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      t_sizes();
      t_ways();
      t_spec();
      t_power();
      report_and_stop();
   end
endmodule : fra_top_bench
bind fra_top fra_top_asserts u_chk (.clk_sys(clk_sys), .rst(rst),
   .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_ready(bus_ready),
   .bus_err(bus_err), .pwr_flash_ok(pwr_flash_ok), .flash_wait(flash_wait),
   .fl_rd(fl_rd), .fl_addr(fl_addr));
